//--- rtl/ecm_pkg.sv
// What this block does
// - config bit 0 selects run or shutdown
// - config bit 7 enables port change detection
// - mask write stores port masks, keeps flag
// - mask read returns flag, then clears it
// - unassigned register bits read as zero
package ecm_pkg;
   // ----------------------------------------
   // register address codes
   // ----------------------------------------
   localparam logic [7:0] ECM_ADDR_CFG = 8'h04;
   localparam logic [7:0] ECM_ADDR_MASK = 8'h06;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int ECM_CFG_RUN_BIT = 0;
   localparam int ECM_CFG_DET_BIT = 7;
   localparam int ECM_MASK_FLAG_BIT = 7;
   localparam int ECM_NPORTS = 7;
   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic ECM_RST_RUN = 1'b0;
   localparam logic ECM_RST_DET = 1'b0;
   localparam logic [6:0] ECM_RST_MASK = 7'h00;
   localparam logic ECM_RST_FLAG = 1'b0;
   localparam logic [7:0] ECM_RST_RDATA = 8'h00;
   // ----------------------------------------
   // synchroniser depth in cycles
   // ----------------------------------------
   localparam int ECM_SYNC_STAGES = 2;
endpackage

//--- rtl/ecm_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser, one per bit, first stage read only by the second
module ecm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // two stages, constant reset values
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

//--- rtl/ecm_regs.sv
`timescale 1ns/100ps
// configuration and change mask registers of the port expander
module ecm_regs
   import ecm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic lk_clk,
   input wire logic lk_wr_en,
   input wire logic lk_rd_en,
   input wire logic [7:0] lk_addr,
   input wire logic [7:0] lk_wdata,
   output logic [7:0] lk_rdata_r,
   input wire logic [ECM_NPORTS-1:0] port_in,
   output logic run_mode_r,
   output logic det_en_r,
   output logic change_flag_r
);
   // ----------------------------------------
   // link domain state
   // ----------------------------------------
   logic lk_run_r;
   logic lk_det_r;
   logic [6:0] lk_mask_r;
   logic lk_clr_tog_r;
   logic lk_flag_s;
   logic [7:0] lk_rdata_nxt;
   logic lk_rd_mask;
   logic lk_wr_cfg;
   logic lk_wr_mask;

   // ----------------------------------------
   // core domain state
   // ----------------------------------------
   logic [8:0] cfg_s;
   logic [ECM_NPORTS-1:0] pin_s;
   logic [ECM_NPORTS-1:0] pin_d_r;
   logic clr_s;
   logic clr_d_r;
   logic clr_pulse;
   logic [ECM_NPORTS-1:0] chg;
   logic change_flag_nxt;

   // ----------------------------------------
   // link side register access
   // ----------------------------------------
   // address decode of the serial engine strobes
   assign lk_wr_cfg = lk_wr_en && (lk_addr == ECM_ADDR_CFG);
   assign lk_wr_mask = lk_wr_en && (lk_addr == ECM_ADDR_MASK);
   assign lk_rd_mask = lk_rd_en && (lk_addr == ECM_ADDR_MASK);

   // configuration register, only run and detect bits are stored
   always_ff @(posedge lk_clk or negedge resetn) begin
      if (!resetn) begin
         lk_run_r <= ECM_RST_RUN;
         lk_det_r <= ECM_RST_DET;
      end else if (lk_wr_cfg) begin
         lk_run_r <= lk_wdata[ECM_CFG_RUN_BIT];
         lk_det_r <= lk_wdata[ECM_CFG_DET_BIT];
      end
   end

   // mask register, the written flag bit is dropped
   always_ff @(posedge lk_clk or negedge resetn) begin
      if (!resetn) begin
         lk_mask_r <= ECM_RST_MASK;
      end else if (lk_wr_mask) begin
         lk_mask_r <= lk_wdata[6:0];
      end
   end

   // read data mux, unused bits and unmapped codes give zero
   always_comb begin
      lk_rdata_nxt = 8'h00;
      case (lk_addr)
         ECM_ADDR_CFG: begin
            lk_rdata_nxt[ECM_CFG_RUN_BIT] = lk_run_r;
            lk_rdata_nxt[ECM_CFG_DET_BIT] = lk_det_r;
         end
         ECM_ADDR_MASK: begin
            lk_rdata_nxt[6:0] = lk_mask_r;
            lk_rdata_nxt[ECM_MASK_FLAG_BIT] = lk_flag_s;
         end
         default: begin
            lk_rdata_nxt = 8'h00;
         end
      endcase
   end

   // read data captured on the read strobe
   always_ff @(posedge lk_clk or negedge resetn) begin
      if (!resetn) begin
         lk_rdata_r <= ECM_RST_RDATA;
      end else if (lk_rd_en) begin
         lk_rdata_r <= lk_rdata_nxt;
      end
   end

   // a read that returned the flag set asks the core to clear it
   always_ff @(posedge lk_clk or negedge resetn) begin
      if (!resetn) begin
         lk_clr_tog_r <= 1'b0;
      end else if (lk_rd_mask && lk_flag_s) begin
         lk_clr_tog_r <= ~lk_clr_tog_r;
      end
   end

   // pending flag brought over to the link domain
   ecm_sync #(.WIDTH(1)) u_flag_sync (
      .clk(lk_clk),
      .resetn(resetn),
      .d(change_flag_r),
      .q(lk_flag_s)
   );

   // ----------------------------------------
   // crossings into the core domain
   // ----------------------------------------
   // quasi-static register bits, each bit independent
   ecm_sync #(.WIDTH(9)) u_cfg_sync (
      .clk(clk),
      .resetn(resetn),
      .d({lk_det_r, lk_run_r, lk_mask_r}),
      .q(cfg_s)
   );

   // port pins come from outside
   ecm_sync #(.WIDTH(ECM_NPORTS)) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .d(port_in),
      .q(pin_s)
   );

   // clear request toggle
   ecm_sync #(.WIDTH(1)) u_clr_sync (
      .clk(clk),
      .resetn(resetn),
      .d(lk_clr_tog_r),
      .q(clr_s)
   );

   // ----------------------------------------
   // core side control and change detection
   // ----------------------------------------
   // control outputs follow the synchronised configuration
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_mode_r <= ECM_RST_RUN;
         det_en_r <= ECM_RST_DET;
      end else begin
         run_mode_r <= cfg_s[7];
         det_en_r <= cfg_s[8];
      end
   end

   // previous pin levels and clear toggle for edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_d_r <= '0;
         clr_d_r <= 1'b0;
      end else begin
         pin_d_r <= pin_s;
         clr_d_r <= clr_s;
      end
   end

   assign clr_pulse = clr_s ^ clr_d_r;
   // masked transitions count only while detection is enabled
   assign chg = (pin_s ^ pin_d_r) & cfg_s[6:0] & {ECM_NPORTS{det_en_r}};

   // sticky flag, a new change wins over a clear in the same cycle
   always_comb begin
      change_flag_nxt = change_flag_r;
      if (|chg) begin
         change_flag_nxt = 1'b1;
      end else if (clr_pulse) begin
         change_flag_nxt = 1'b0;
      end
   end

   // pending change flag register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         change_flag_r <= ECM_RST_FLAG;
      end else begin
         change_flag_r <= change_flag_nxt;
      end
   end

   // ----------------------------------------
   // assertions, link domain
   // ----------------------------------------
   cfg_run_wr_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      lk_wr_cfg ##2 (lk_rd_en && lk_addr == ECM_ADDR_CFG && !lk_wr_en)
      |=> lk_rdata_r[0] == $past(lk_wdata[0], 3))
      else $error("config run bit not read back");

   cfg_det_wr_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      lk_wr_cfg |=> lk_det_r == $past(lk_wdata[7]))
      else $error("config detect bit not stored");

   mask_wr_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      lk_wr_mask |=> lk_mask_r == $past(lk_wdata[6:0]) && lk_clr_tog_r == $past(lk_clr_tog_r))
      else $error("mask write wrong or touched flag");

   flag_read_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      (lk_rd_mask && lk_flag_s) |=> lk_rdata_r[7] && lk_clr_tog_r != $past(lk_clr_tog_r))
      else $error("flag read did not report and clear");

   unused_zero_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      (lk_rd_en && lk_addr != ECM_ADDR_CFG && lk_addr != ECM_ADDR_MASK)
      or (lk_rd_en && lk_addr == ECM_ADDR_CFG)
      |=> (lk_rdata_r[6:1] == 6'h00) && ($past(lk_addr) == ECM_ADDR_CFG || lk_rdata_r == 8'h00))
      else $error("unassigned bits not zero");

   // config read returns the stored run and detect bits
   cfg_rdback_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      (lk_rd_en && lk_addr == ECM_ADDR_CFG)
      |=> lk_rdata_r[ECM_CFG_RUN_BIT] == $past(lk_run_r) && lk_rdata_r[ECM_CFG_DET_BIT] == $past(lk_det_r))
      else $error("config read data wrong");

   // mask read returns the masks and the synchronised flag
   mask_rdback_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      lk_rd_mask
      |=> lk_rdata_r[6:0] == $past(lk_mask_r) && lk_rdata_r[ECM_MASK_FLAG_BIT] == $past(lk_flag_s))
      else $error("mask read data wrong");

   // read data stands until the next read strobe
   rdata_hold_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      !lk_rd_en
      |=> $stable(lk_rdata_r))
      else $error("read data changed without a read");

   // no clear request without a read that saw the flag
   clr_hold_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      !(lk_rd_mask && lk_flag_s)
      |=> $stable(lk_clr_tog_r))
      else $error("clear request without flag read");

   // port masks change only on a mask write
   mask_keep_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      !lk_wr_mask
      |=> $stable(lk_mask_r))
      else $error("mask changed without a write");

   // run and detect bits change only on a config write
   cfg_keep_a: assert property (@(posedge lk_clk) disable iff (!resetn)
      !lk_wr_cfg
      |=> $stable(lk_run_r) && $stable(lk_det_r))
      else $error("config changed without a write");

   // ----------------------------------------
   // assertions, core domain
   // ----------------------------------------
   no_det_off_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(change_flag_r) |-> $past(det_en_r) && $past(|(cfg_s[6:0] & (pin_s ^ pin_d_r))))
      else $error("flag set without enabled masked change");

   det_set_a: assert property (@(posedge clk) disable iff (!resetn)
      (|chg) |=> change_flag_r ##1 (change_flag_r || clr_pulse || $past(clr_pulse)))
      else $error("enabled change did not set flag");

   flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      (clr_pulse && !(|chg)) |=> !change_flag_r)
      else $error("clear request did not clear flag");

   run_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      $changed(cfg_s[7]) |=> run_mode_r == $past(cfg_s[7]) ##1 $stable(run_mode_r) || $changed(cfg_s[7]))
      else $error("run output not following config");

   // detect output follows the synchronised config bit
   det_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      $changed(cfg_s[8])
      |=> det_en_r == $past(cfg_s[8]))
      else $error("detect output not following config");

   // flag keeps its value without change or clear
   flag_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (!(|chg) && !clr_pulse)
      |=> $stable(change_flag_r))
      else $error("flag moved without a cause");

   // flag falls only after a clear request
   clr_only_a: assert property (@(posedge clk) disable iff (!resetn)
      $fell(change_flag_r)
      |-> $past(clr_pulse))
      else $error("flag dropped without clear");

   // ----------------------------------------
   // assertions, values held in reset
   // ----------------------------------------
   // core outputs stay cleared while reset is held
   core_rst_a: assert property (@(posedge clk)
      !resetn
      |-> !run_mode_r && !det_en_r && !change_flag_r)
      else $error("core outputs not cleared in reset");

   // link registers stay cleared while reset is held
   link_rst_a: assert property (@(posedge lk_clk)
      !resetn
      |-> lk_rdata_r == 8'h00 && !lk_run_r && !lk_det_r && lk_mask_r == 7'h00)
      else $error("link registers not cleared in reset");
endmodule

//--- bench/ecm_host.sv
`timescale 1ns/100ps
// host master driving the register link, one strobe per access
module ecm_host
   import ecm_pkg::*;
(
   input wire logic lk_clk,
   output logic lk_wr_en,
   output logic lk_rd_en,
   output logic [7:0] lk_addr,
   output logic [7:0] lk_wdata
);
   // idle lines at time zero
   initial begin
      lk_wr_en = 1'b0;
      lk_rd_en = 1'b0;
      lk_addr = 8'h00;
      lk_wdata = 8'h00;
   end
   // write strobe, then release lines to inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge lk_clk);
      lk_wr_en <= 1'b1;
      lk_addr <= a;
      lk_wdata <= (a == ECM_ADDR_CFG) ? (d & 8'hbf) : d;
      @(posedge lk_clk);
      lk_wr_en <= 1'b0;
      lk_addr <= ~a;
      lk_wdata <= ~lk_wdata;
   endtask
   // read strobe, data taken by the bench after the same edge
   task automatic rd(input logic [7:0] a);
      @(posedge lk_clk);
      lk_rd_en <= 1'b1;
      lk_addr <= a;
      @(posedge lk_clk);
      lk_rd_en <= 1'b0;
      lk_addr <= ~a;
   endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
// ----------------------------------------
// register bank bench
// ----------------------------------------
module tb;
   import ecm_pkg::*;
   logic clk, resetn, lk_clk, lk_wr_en, lk_rd_en;
   logic [7:0] lk_addr, lk_wdata, lk_rdata_r;
   logic [6:0] port_in, msk;
   logic run_mode_r, det_en_r, change_flag_r;
   logic [15:0] rnd;
   logic [7:0] exp_q[$];
   int fails = 0;
   int cmp_count = 0;
   ecm_regs u_ecm_regs (.clk(clk), .resetn(resetn), .lk_clk(lk_clk), .lk_wr_en(lk_wr_en),
      .lk_rd_en(lk_rd_en), .lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_rdata_r(lk_rdata_r),
      .port_in(port_in), .run_mode_r(run_mode_r), .det_en_r(det_en_r), .change_flag_r(change_flag_r));
   ecm_host u_ecm_host (.lk_clk(lk_clk), .lk_wr_en(lk_wr_en), .lk_rd_en(lk_rd_en),
      .lk_addr(lk_addr), .lk_wdata(lk_wdata));
   // core and link clocks
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      lk_clk = 1'b0;
      #7;
      forever #24 lk_clk = ~lk_clk;
   end
   // lfsr step for random stimulus
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // read with its expected value noted in the queue
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_ecm_host.rd(a);
   endtask
   // bounded wait on the change flag
   task automatic wait_flag(input logic v);
      for (int k = 0; k < 20 && change_flag_r !== v; k++) @(posedge clk);
      if (change_flag_r !== v) begin
         fails++;
         tally_and_finish();
      end
   endtask
   // watcher: compares read data against the oldest note
   always @(posedge lk_clk) begin
      if (lk_rd_en === 1'b1) begin
         #1;
         if (exp_q.size() == 0) begin
            fails++;
            $display("CHECK FAILED %0t read without expected value", $time);
         end else begin
            `CHK(lk_rdata_r, exp_q.pop_front(), "read data")
         end
      end
   end
   initial begin
      resetn = 1'b0;
      port_in = 7'h00;
      rnd = 16'hde72;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      `CHK({run_mode_r, det_en_r, change_flag_r}, 3'b000, "reset outputs")
      rdx(ECM_ADDR_CFG, 8'h00);
      rdx(ECM_ADDR_MASK, 8'h00);
      $display("reset test done");
      // every run and detect mode, unused bits 1 to 5 written as ones, bit 6 cleared by the host write task
      for (int i = 0; i < 4; i++) begin
         u_ecm_host.wr(ECM_ADDR_CFG, {i[1], 6'h3f, i[0]});
         rdx(ECM_ADDR_CFG, {i[1], 6'h00, i[0]});
         repeat (8) @(posedge clk);
         `CHK(run_mode_r, i[0], "run bit")
         `CHK(det_en_r, i[1], "detect bit")
      end
      $display("config test done");
      rnd = nx(rnd);
      msk = rnd[6:0] | 7'h01;
      u_ecm_host.wr(ECM_ADDR_MASK, {1'b1, msk});
      rdx(ECM_ADDR_MASK, {1'b0, msk});
      @(posedge clk) port_in <= port_in ^ (rnd[13:7] & ~msk);
      repeat (10) @(posedge clk);
      `CHK(change_flag_r, 1'b0, "masked pins")
      @(posedge clk) port_in <= port_in ^ 7'h01;
      wait_flag(1'b1);
      `CHK(change_flag_r, 1'b1, "change seen")
      repeat (4) @(posedge lk_clk);
      rdx(ECM_ADDR_MASK, {1'b1, msk});
      wait_flag(1'b0);
      `CHK(change_flag_r, 1'b0, "flag cleared")
      repeat (4) @(posedge lk_clk);
      rdx(ECM_ADDR_MASK, {1'b0, msk});
      $display("change test done");
      // detection off: an enabled pin edge is ignored
      u_ecm_host.wr(ECM_ADDR_CFG, 8'h01);
      repeat (8) @(posedge clk);
      @(posedge clk) port_in <= port_in ^ 7'h01;
      repeat (10) @(posedge clk);
      `CHK(change_flag_r, 1'b0, "detect off")
      rdx(8'h05, 8'h00);
      u_ecm_host.wr(8'h05, 8'hff);
      rdx(ECM_ADDR_CFG, 8'h01);
      rdx(ECM_ADDR_MASK, {1'b0, msk});
      repeat (2) @(posedge lk_clk);
      $display("disable test done");
      tally_and_finish();
   end
endmodule
